/* File: hw/mebm_cfg.svh */
`ifndef MEBM_CFG_SVH
`define MEBM_CFG_SVH
// mode code = {mode_select_c, mode_select_b, mode_select_a}
`define MEBM_MODE_SS        3'h0
`define MEBM_MODE_EMU_NARROW 3'h1
`define MEBM_MODE_SPC_TEST  3'h2
`define MEBM_MODE_EMU_WIDE  3'h3
`define MEBM_MODE_NS        3'h4
`define MEBM_MODE_NARROW    3'h5
`define MEBM_MODE_PERIPH    3'h6
`define MEBM_MODE_WIDE      3'h7
`define MEBM_MODE_RESET     3'h0
`define MEBM_SPECIAL_BIT    2
`define MEBM_SYNC_STAGES    3
`define MEBM_STRETCH_NS     10
`define MEBM_CLK_NS         5
`define MEBM_STRETCH_CYC    ((`MEBM_STRETCH_NS + `MEBM_CLK_NS - 1) / `MEBM_CLK_NS)
`endif

/* File: hw/mebm_pkg.sv */
package mebm_pkg;
  typedef enum logic [1:0] {MEBM_IDLE, MEBM_ADDR, MEBM_DATA, MEBM_DATA2} mebm_phase_e;
  typedef logic [2:0] mebm_mode_t;
endpackage : mebm_pkg

/* File: hw/mebm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three stages; output changes once stages two and three agree
module mebm_sync
(
  input  wire logic clk,    // destination clock
  input  wire logic rst_n,  // async reset
  input  wire logic ce,     // clock enable
  input  wire logic din,    // async level
  output logic      dout    // filtered level
);
  logic [2:0] s_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q  <= 3'h0;
      dout <= 1'b0;
    end
    else if (ce)
    begin
      s_q <= {s_q[1:0], din};
      if (s_q[1] == s_q[2])
        dout <= s_q[2];
    end
  end
endmodule : mebm_sync
`default_nettype wire

/* File: hw/mebm_link.sv */
`timescale 1ns/1ps
`default_nettype none
// link-clock side: samples the tag pin on falling edge of the bus clock
module mebm_link
(
  input  wire logic link_clk,       // link clock, bus_timing_clock
  input  wire logic rst_n,          // async reset
  input  wire logic high_half_tag,  // tag pin, active low
  input  wire logic tag_en,         // tagging enable, synchronised here
  output logic      tag_toggle      // toggles per tagged fetch
);
  logic en_m_q;
  logic en_q;
  always_ff @(negedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_m_q     <= 1'b0;
      en_q       <= 1'b0;
      tag_toggle <= 1'b0;
    end
    else
    begin
      en_m_q <= tag_en;
      en_q   <= en_m_q;
      if (en_q && !high_half_tag)
        tag_toggle <= ~tag_toggle;
    end
  end
endmodule : mebm_link
`default_nettype wire

/* File: hw/mebm_core.sv */
// Functional notes
// - capture the three mode-select pins at reset release into mode bits.
// - internal 16-bit accesses go out as 8-bit or 16-bit per mode and control.
// - wide expanded: both ports form 16-bit muxed address/data bus.
// - narrow expanded: 16-bit address on both ports, 8-bit data on high port.
// - normal single-chip: no bus, ports left as general-purpose I/O.
// - special single-chip: no bus after reset, debug controls execution.
// - special test: wide bus and write protection lifted.
// - peripheral mode: processor inactive, tester drives address, data, control.
// - high address byte on high port while bus clock low; input in peripheral.
// - low address byte on low port while bus clock low; input in peripheral.
// - high port carries high data in bus clock high, wide/peripheral/visible.
// - low port carries low data in bus clock high; read/write gives direction.
// - narrow: high port carries high then low data bytes while clock high.
// - with tagging on, tag pin low at bus clock fall tags high half.
// - free-cycle flag output only in expanded modes.
// - pipe status bits output only while pipe output enable set.
// - clock test output only in special modes; pipe enable wins the pin.
// - read/write is output in expanded modes except peripheral mode, where it is input; not driven in single-chip modes.
// - bus clock free-running or one pulse per access, high phase stretched.
// - low strobe low means valid data on low data byte.
`timescale 1ns/1ps
`default_nettype none
`include "mebm_cfg.svh"
module mebm_core
(
  input  wire logic        ref_clk,             // system clock
  input  wire logic        rst_n,               // async reset, active low
  input  wire logic        clk_en,              // clock enable
  input  wire logic        mode_select_a,       // mode strap a
  input  wire logic        mode_select_b,       // mode strap b
  input  wire logic        mode_select_c,       // mode strap c
  input  wire logic        mode_wr,             // software mode write strobe
  input  wire logic [2:0]  mode_wr_data,        // software mode value
  input  wire logic        narrow_ctl,          // force 8-bit external access
  input  wire logic        internal_visibility, // show internal accesses
  input  wire logic        free_run_clk,        // bus clock free-running
  input  wire logic        stretch_en,          // stretch high phase
  input  wire logic        tag_en,              // instruction tagging on
  input  wire logic        pipe_output_enable,  // pipe status to pins
  input  wire logic        clk_test_en,         // clock test enable
  input  wire logic        req,                 // internal access request
  input  wire logic        req_internal,        // access targets internal space
  input  wire logic        req_write,           // 1 write, 0 read
  input  wire logic        req_byte,            // 8-bit access
  input  wire logic [15:0] req_addr,            // access address
  input  wire logic [15:0] req_wdata,           // write data
  input  wire logic        free_cycle,          // processor free cycle
  input  wire logic [1:0]  pipe_status,         // processor pipe status
  input  wire logic        link_clk,            // bus timing clock as seen back
  input  wire logic        high_half_tag,       // tag pin, active low
  input  wire logic [7:0]  port_hi_in,          // high port input
  input  wire logic [7:0]  port_lo_in,          // low port input
  input  wire logic        rw_in,               // read/write pin input
  output logic [7:0]       port_hi_out,         // high port output
  output logic             port_hi_oe,          // high port drive
  output logic [7:0]       port_lo_out,         // low port output
  output logic             port_lo_oe,          // low port drive
  output logic             rw_out,              // read/write pin output
  output logic             rw_oe,               // read/write drive
  output logic             low_byte_strobe_n,   // low data byte valid, low
  output logic             bus_timing_clock,    // bus clock out
  output logic             free_cycle_flag,     // free-cycle indication
  output logic             free_cycle_oe,       // free-cycle pin drive
  output logic             pipe_status_0,       // pipe status bit 0
  output logic             pipe_status_1,       // pipe status bit 1
  output logic             pipe_oe,             // pipe pins drive
  output logic             sys_clock_test_out,  // clock test output
  output logic [2:0]       mode_q,              // operating mode
  output logic             cpu_hold,            // processor held inactive
  output logic             prot_lifted,         // write protection lifted
  output logic             debug_active,        // debug controls execution
  output logic             busy,                // access in progress
  output logic [15:0]      rdata,               // read data
  output logic             rdone,               // access done pulse
  output logic             tag_hit,             // high half tagged pulse
  output logic [2:0]       rw_sync,             // tester periph/rw view
  output logic [15:0]      tester_addr          // tester address sampled
);
  function automatic logic is_expanded(input logic [2:0] m);
    is_expanded = m[0] | (m == `MEBM_MODE_SPC_TEST) | (m == `MEBM_MODE_PERIPH);
  endfunction : is_expanded
  function automatic logic is_wide(input logic [2:0] m);
    is_wide = (m == `MEBM_MODE_WIDE) | (m == `MEBM_MODE_EMU_WIDE) | (m == `MEBM_MODE_SPC_TEST)
              | (m == `MEBM_MODE_PERIPH);
  endfunction : is_wide

  mebm_pkg::mebm_phase_e ph_q;
  mebm_pkg::mebm_phase_e ph_d;
  logic                  strap_q;
  logic [15:0]           addr_q;
  logic [15:0]           wdata_q;
  logic                  wr_q;
  logic                  byte_q;
  logic [3:0]            cnt_q;
  logic                  rw_s;
  logic                  tog_q;
  logic                  tog_s;
  logic                  tag_tog;

  // modes with a bus; single-chip modes never drive the ports
  wire exp_w    = is_expanded(mode_q);
  wire periph_w = (mode_q == `MEBM_MODE_PERIPH);
  wire wide_w   = is_wide(mode_q);
  // narrow mode or byte access in wide mode uses the high port only
  wire narrow_w = !wide_w || narrow_ctl || byte_q;
  wire visible  = !req_internal || internal_visibility;
  wire start_w  = req && !busy && exp_w && !periph_w && visible;
  wire stretch_done = (cnt_q == 4'(`MEBM_STRETCH_CYC)) || !stretch_en;
  wire data_end = stretch_done && (!narrow_w || ph_q == mebm_pkg::MEBM_DATA2 || byte_q);

  always_comb
  begin
    ph_d = ph_q;
    unique case (ph_q)
      mebm_pkg::MEBM_IDLE:  if (start_w) ph_d = mebm_pkg::MEBM_ADDR;
      mebm_pkg::MEBM_ADDR:  ph_d = mebm_pkg::MEBM_DATA;
      mebm_pkg::MEBM_DATA:  if (stretch_done) ph_d = data_end ? mebm_pkg::MEBM_IDLE : mebm_pkg::MEBM_DATA2;
      mebm_pkg::MEBM_DATA2: if (stretch_done) ph_d = mebm_pkg::MEBM_IDLE;
    endcase
  end

  // mode strap caught by clocked process on first enabled edge after release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_q <= 1'b0;
      mode_q  <= `MEBM_MODE_RESET;
    end
    else if (clk_en)
    begin
      strap_q <= 1'b1;
      if (!strap_q)
        mode_q <= {mode_select_c, mode_select_b, mode_select_a};
      else if (mode_wr && mode_q[`MEBM_SPECIAL_BIT] == 1'b0)
        mode_q <= mode_wr_data; // special modes only may rewrite
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q    <= mebm_pkg::MEBM_IDLE;
      cnt_q   <= 4'h0;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
      wr_q    <= 1'b0;
      byte_q  <= 1'b0;
      busy    <= 1'b0;
      rdata   <= 16'h0000;
      rdone   <= 1'b0;
    end
    else if (clk_en)
    begin
      ph_q  <= ph_d;
      rdone <= 1'b0;
      cnt_q <= (ph_d != ph_q) ? 4'h0 : cnt_q + 4'h1;
      if (start_w)
      begin
        addr_q  <= req_addr;
        wdata_q <= req_wdata;
        wr_q    <= req_write;
        byte_q  <= req_byte;
        busy    <= 1'b1;
      end
      if (ph_q == mebm_pkg::MEBM_DATA && stretch_done && !wr_q)
      begin
        if (!narrow_w)
          rdata <= {port_hi_in, port_lo_in};
        else
          rdata[15:8] <= port_hi_in;
      end
      if (ph_q == mebm_pkg::MEBM_DATA2 && stretch_done && !wr_q)
        rdata[7:0] <= port_hi_in;
      if (ph_q != mebm_pkg::MEBM_IDLE && ph_d == mebm_pkg::MEBM_IDLE)
      begin
        busy  <= 1'b0;
        rdone <= 1'b1;
      end
    end
  end

  // pin drive, registered; address during clock low, data during clock high
  wire addr_ph = (ph_d == mebm_pkg::MEBM_ADDR);
  wire d1_ph   = (ph_d == mebm_pkg::MEBM_DATA);
  wire d2_ph   = (ph_d == mebm_pkg::MEBM_DATA2);
  // take edge already drives the address; the copies are loaded only at that edge
  wire [15:0] acc_addr   = start_w ? req_addr : addr_q;
  wire        acc_wr     = start_w ? req_write : wr_q;
  wire        acc_byte   = start_w ? req_byte : byte_q;
  wire        acc_narrow = !wide_w || narrow_ctl || acc_byte;
  wire [7:0] hi_d = addr_ph ? acc_addr[15:8] : (d2_ph ? wdata_q[7:0] : wdata_q[15:8]);
  wire [7:0] lo_d = addr_ph ? acc_addr[7:0] : wdata_q[7:0];
  wire clk_d = free_run_clk ? !bus_timing_clock : (d1_ph || d2_ph);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_hi_out       <= 8'h00;
      port_hi_oe        <= 1'b0;
      port_lo_out       <= 8'h00;
      port_lo_oe        <= 1'b0;
      rw_out            <= 1'b1;
      rw_oe             <= 1'b0;
      low_byte_strobe_n <= 1'b1;
      bus_timing_clock  <= 1'b0;
    end
    else if (clk_en)
    begin
      port_hi_out <= hi_d;
      port_lo_out <= lo_d;
      port_hi_oe  <= !periph_w && (addr_ph || ((d1_ph || d2_ph) && wr_q));
      port_lo_oe  <= !periph_w && (addr_ph || (d1_ph && wr_q && !narrow_w));
      rw_out      <= !acc_wr;
      rw_oe       <= exp_w && !periph_w;
      low_byte_strobe_n <= !((addr_ph || d1_ph) && (!acc_byte || acc_addr[0]) && !acc_narrow);
      bus_timing_clock  <= exp_w && clk_d;
    end
  end

  // status pins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      free_cycle_flag    <= 1'b0;
      free_cycle_oe      <= 1'b0;
      pipe_status_0      <= 1'b0;
      pipe_status_1      <= 1'b0;
      pipe_oe            <= 1'b0;
      sys_clock_test_out <= 1'b0;
      cpu_hold           <= 1'b0;
      prot_lifted        <= 1'b0;
      debug_active       <= 1'b0;
    end
    else if (clk_en)
    begin
      free_cycle_flag    <= exp_w && free_cycle;
      free_cycle_oe      <= exp_w;
      pipe_status_0      <= pipe_output_enable && pipe_status[0];
      pipe_status_1      <= pipe_output_enable ? pipe_status[1] : (clk_test_en && !mode_q[2] && !bus_timing_clock);
      pipe_oe            <= pipe_output_enable;
      // half-rate square wave, so the pin really shows a clock
      sys_clock_test_out <= !pipe_output_enable && clk_test_en && !mode_q[2] && !sys_clock_test_out;
      cpu_hold           <= periph_w;
      prot_lifted        <= (mode_q == `MEBM_MODE_SPC_TEST);
      debug_active       <= (mode_q == `MEBM_MODE_SS);
    end
  end

  // tester side: read/write pin passes three stages; address pins are sampled directly
  mebm_sync u_rw_sync
  (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (clk_en),
    .din   (rw_in),
    .dout  (rw_s)
  );
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rw_sync     <= 3'h0;
      tester_addr <= 16'h0000;
      tog_q       <= 1'b0;
      tag_hit     <= 1'b0;
    end
    else if (clk_en)
    begin
      rw_sync <= {periph_w, rw_s, periph_w && rw_s};
      // tester holds the address steady while it owns the pins
      if (periph_w)
        tester_addr <= {port_hi_in, port_lo_in};
      tog_q   <= tog_s;
      tag_hit <= tog_q ^ tog_s;
    end
  end

  mebm_link u_link
  (
    .link_clk      (link_clk),
    .rst_n         (rst_n),
    .high_half_tag (high_half_tag),
    .tag_en        (tag_en),
    .tag_toggle    (tag_tog)
  );
  mebm_sync u_tag_sync
  (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (clk_en),
    .din   (tag_tog),
    .dout  (tog_s)
  );

  property mode_hold_p;
    @(posedge ref_clk) disable iff (!rst_n)
    (strap_q && clk_en && !mode_wr) |=> $stable(mode_q);
  endproperty
  mode_hold_a: assert property (mode_hold_p) else $error("mode changed without write");
  single_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !exp_w |-> ##1 !port_hi_oe && !port_lo_oe) else $error("port driven in single chip");
  periph_input_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    periph_w && clk_en |=> !port_hi_oe && !rw_oe) else $error("driving in peripheral mode");
  pipe_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pipe_output_enable && clk_en |=> !pipe_oe) else $error("pipe pins without enable");
  clk_test_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sys_clock_test_out |-> !$past(mode_q[2])) else $error("clock test out in normal mode");
  free_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    free_cycle_flag |-> free_cycle_oe) else $error("free flag outside expanded");
  sequence addr_seq;
    ph_q == mebm_pkg::MEBM_ADDR && clk_en;
  endsequence
  addr_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_seq |-> !bus_timing_clock || free_run_clk) else $error("address with clock high");
  access_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_w && clk_en |-> ##[1:40] rdone) else $error("access never finished");
  rw_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && exp_w && !periph_w |=> rw_oe) else $error("rw not driven");
endmodule : mebm_core
`default_nettype wire

/* File: verification/mebm_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mebm_cfg.svh"
module mebm_ext_mem
(
  input  wire logic        ref_clk,          // system clock
  input  wire logic        narrow,           // 8-bit data on high port
  input  wire logic        periph,           // tester owns the pins
  input  wire logic        stretch,          // high phase stretched
  input  wire logic [16:0] tester_drv,       // tester {rw, address}
  input  wire logic [7:0]  port_hi_out,      // high port from device
  input  wire logic [7:0]  port_lo_out,      // low port from device
  input  wire logic        port_hi_oe,       // high port drive
  input  wire logic        rw_out,           // 1 read
  input  wire logic        bus_timing_clock, // bus clock
  output logic [7:0]       port_hi_in,       // high port to device
  output logic [7:0]       port_lo_in,       // low port to device
  output logic             rw_in             // tester direction
);
  logic [15:0] addr_q;
  logic        second_q;
  logic [16:0] junk_q;
  logic [3:0]  hi_cnt_q;
  wire  [15:0] rd_data = addr_q ^ 16'ha55a;
  // released lines never hold the last value
  always @(posedge ref_clk)
  begin
    junk_q <= ~junk_q;
    if (!bus_timing_clock && port_hi_oe)
    begin
      addr_q   <= {port_hi_out, port_lo_out};
      second_q <= 1'b0;
      hi_cnt_q <= 4'h0;
    end
    else if (bus_timing_clock)
    begin
      hi_cnt_q <= hi_cnt_q + 4'h1;
      // first byte stands for the whole first high phase, stretched or not
      if (hi_cnt_q + 4'h1 >= (stretch ? 4'(`MEBM_STRETCH_CYC + 1) : 4'h1))
        second_q <= narrow;
    end
  end
  initial junk_q = 17'h0a5c3;
  always_comb
  begin
    {rw_in, port_hi_in, port_lo_in} = junk_q;
    if (periph)
      {rw_in, port_hi_in, port_lo_in} = tester_drv;
    else if (bus_timing_clock && rw_out && !port_hi_oe)
    begin
      port_hi_in = second_q ? rd_data[7:0] : rd_data[15:8];
      port_lo_in = rd_data[7:0];
    end
  end
endmodule : mebm_ext_mem
`default_nettype wire

/* File: verification/mebm_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mebm_cfg.svh"
module mebm_core_test;
  logic ref_clk, rst_n, link_clk, mode_select_a, mode_select_b, mode_select_c, mode_wr;
  logic narrow_ctl, internal_visibility, free_run_clk, stretch_en, tag_en, pipe_output_enable;
  logic clk_test_en, req, req_internal, req_write, req_byte, free_cycle, high_half_tag, rw_in, clk_en;
  logic [2:0] mode_wr_data;
  logic [1:0] pipe_status;
  logic [15:0] req_addr, req_wdata, rdata, tester_addr;
  logic [7:0] port_hi_in, port_lo_in, port_hi_out, port_lo_out;
  logic port_hi_oe, port_lo_oe, rw_out, rw_oe, low_byte_strobe_n, bus_timing_clock, free_cycle_flag;
  logic free_cycle_oe, pipe_status_0, pipe_status_1, pipe_oe, sys_clock_test_out, cpu_hold;
  logic prot_lifted, debug_active, busy, rdone, tag_hit, narrow_now, periph_now;
  logic [2:0] mode_q, rw_sync;
  logic [16:0] tester_drv;
  logic [15:0] seen_addr;
  logic [7:0] first_hi, last_hi, last_lo;
  logic seen_first, strobe_seen, rw_seen;
  logic [31:0] seed;
  int bad_count, check_count, tag_cnt;
  logic [15:0] expq[$];

  mebm_core i_mebm_core (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .mode_select_a(mode_select_a),
    .mode_select_b(mode_select_b), .mode_select_c(mode_select_c), .mode_wr(mode_wr), .mode_wr_data(mode_wr_data),
    .narrow_ctl(narrow_ctl), .internal_visibility(internal_visibility), .free_run_clk(free_run_clk),
    .stretch_en(stretch_en), .tag_en(tag_en), .pipe_output_enable(pipe_output_enable), .clk_test_en(clk_test_en),
    .req(req), .req_internal(req_internal), .req_write(req_write), .req_byte(req_byte), .req_addr(req_addr),
    .req_wdata(req_wdata), .free_cycle(free_cycle), .pipe_status(pipe_status), .link_clk(link_clk),
    .high_half_tag(high_half_tag), .port_hi_in(port_hi_in), .port_lo_in(port_lo_in), .rw_in(rw_in),
    .port_hi_out(port_hi_out), .port_hi_oe(port_hi_oe), .port_lo_out(port_lo_out), .port_lo_oe(port_lo_oe),
    .rw_out(rw_out), .rw_oe(rw_oe), .low_byte_strobe_n(low_byte_strobe_n), .bus_timing_clock(bus_timing_clock),
    .free_cycle_flag(free_cycle_flag), .free_cycle_oe(free_cycle_oe), .pipe_status_0(pipe_status_0),
    .pipe_status_1(pipe_status_1), .pipe_oe(pipe_oe), .sys_clock_test_out(sys_clock_test_out), .mode_q(mode_q),
    .cpu_hold(cpu_hold), .prot_lifted(prot_lifted), .debug_active(debug_active), .busy(busy), .rdata(rdata),
    .rdone(rdone), .tag_hit(tag_hit), .rw_sync(rw_sync), .tester_addr(tester_addr));
  mebm_ext_mem i_mebm_ext_mem (.ref_clk(ref_clk), .narrow(narrow_now), .periph(periph_now), .stretch(stretch_en),
    .tester_drv(tester_drv), .port_hi_out(port_hi_out), .port_lo_out(port_lo_out), .port_hi_oe(port_hi_oe),
    .rw_out(rw_out), .bus_timing_clock(bus_timing_clock), .port_hi_in(port_hi_in), .port_lo_in(port_lo_in),
    .rw_in(rw_in));

  initial
  begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  // wire watcher: address while bus clock low, data while high
  always @(posedge ref_clk)
  begin
    #1;
    if (port_hi_oe && !bus_timing_clock)
    begin
      seen_addr = {port_hi_out, port_lo_out};
      seen_first = 0;
    end
    else if (bus_timing_clock)
    begin
      strobe_seen = low_byte_strobe_n;
      rw_seen = rw_out;
      if (port_hi_oe && !seen_first)
        first_hi = port_hi_out;
      if (port_hi_oe)
        seen_first = 1;
      last_hi = port_hi_out;
      last_lo = port_lo_out;
    end
    if (tag_hit === 1'b1)
      tag_cnt++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles

  task automatic boot(input logic [2:0] m);
    {mode_select_c, mode_select_b, mode_select_a} = m;
    periph_now = (m == 3'h6);
    rst_n = 0;
    cycles(4);
    check(rw_out, 1);
    check(low_byte_strobe_n, 1);
    rst_n = 1;
    cycles(3);
  endtask : boot

  // nar is the width the rules expect on the wire, not narrow_ctl
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic nar);
    int n;
    int lat;
    // n counts edges after the take edge; each stretch adds the stretch count to a phase
    lat = (nar ? 3 : 2) + (stretch_en ? (nar ? 2 : 1) * `MEBM_STRETCH_CYC : 0);
    narrow_now = nar;
    if (!wr)
      expq.push_back(a ^ 16'ha55a);
    {req_write, req_addr, req_wdata, req} = {wr, a, d, 1'b1};
    @(posedge ref_clk);
    #1;
    req = 0;
    n = 0;
    while (rdone !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n[15:0], lat[15:0]);
    check(seen_addr, a);
    check(rw_seen, !wr);
    if (wr)
      check(nar ? {first_hi, last_hi} : {last_hi, last_lo}, d);
    else
      check(rdata, expq.pop_front());
    if (!nar)
      check(strobe_seen, 0);
  endtask : access

  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end

  initial
  begin
    logic s0, s1;
    int c;
    {rst_n, clk_en, mode_wr, mode_wr_data, narrow_ctl, internal_visibility, free_run_clk, stretch_en} = 10'h100;
    {tag_en, pipe_output_enable, clk_test_en, req, req_internal, req_write, req_byte} = 7'h00;
    {req_addr, req_wdata, free_cycle, pipe_status, high_half_tag, tester_drv, narrow_now} = 54'h0;
    high_half_tag = 1;
    {mode_select_a, mode_select_b, mode_select_c, periph_now, tag_cnt, seed} = {4'h0, 32'd0, 32'd84786};
    for (int m = 0; m < 8; m++)
    begin
      boot(m[2:0]);
      check(mode_q, m[2:0]);
      check(cpu_hold, m == 6);
      check(prot_lifted, m == 2);
      check(debug_active, m == 0);
      check(rw_oe, m[0] || m == 2);
      if (m == 6)
        check({port_hi_oe, port_lo_oe}, 0);
      if (m == 0 || m == 4)
        check(free_cycle_oe, 0);
      if (m[0])
        check(free_cycle_oe, 1);
      for (int i = 0; i < 4; i++)
      begin
        {clk_test_en, pipe_output_enable} = i[1:0];
        {pipe_status, free_cycle} = 3'(rnd());
        cycles(3);
        check(pipe_oe, i[0]);
        if (i[0])
          check({pipe_status_1, pipe_status_0}, pipe_status);
        if (m[0])
          check(free_cycle_flag, free_cycle);
        {s0, s1} = 2'b00;
        repeat (8)
        begin
          cycles(1);
          s0 |= (sys_clock_test_out === 1'b0);
          s1 |= (sys_clock_test_out === 1'b1);
        end
        check(s0 & s1, !m[2] && i == 2);
      end
      {mode_select_c, mode_select_b, mode_select_a} = ~m[2:0];
      {req, req_addr} = {1'b1, 16'(rnd())};
      cycles(1);
      req = 0;
      cycles(4);
      check(mode_q, m[2:0]);
      if (m == 0 || m == 4 || m == 6)
        check(busy, 0);
      {mode_wr, mode_wr_data} = 4'hd;
      cycles(1);
      mode_wr = 0;
      cycles(2);
      check(mode_q, m[2] ? m[2:0] : 3'h5);
    end
    boot(3'h6);
    for (int i = 0; i < 2; i++)
    begin
      tester_drv = {i[0], 16'(rnd())};
      cycles(10);
      check(tester_addr, tester_drv[15:0]);
      check(rw_sync, i[0] ? 3'h7 : 3'h4);
    end
    periph_now = 0;
    boot(3'h7);
    for (int k = 0; k < 24; k++)
    begin
      stretch_en = 1'(rnd());
      narrow_ctl = k[0];
      access(1'(rnd()), 16'(rnd()), 16'(rnd()), k[0]);
    end
    boot(3'h5);
    for (int k = 0; k < 8; k++)
    begin
      {stretch_en, narrow_ctl} = 2'(rnd());
      access(1'(rnd()), 16'(rnd()), 16'(rnd()), 1);
    end
    boot(3'h7);
    free_run_clk = 1;
    cycles(2);
    c = bus_timing_clock;
    cycles(1);
    check(bus_timing_clock, !c);
    free_run_clk = 0;
    {req, req_internal} = 2'b11;
    cycles(1);
    {req, req_internal} = 2'b00;
    check(busy, 0);
    for (int t = 1; t >= 0; t--)
    begin
      tag_en = t[0];
      repeat (3) @(posedge link_clk);
      #1;
      c = tag_cnt;
      high_half_tag = 0;
      @(posedge link_clk);
      #1;
      high_half_tag = 1;
      cycles(30);
      check(tag_cnt - c, t);
    end
    conclude();
  end
endmodule : mebm_core_test
`default_nettype wire
